// [rtl/gpfg_pkg.sv]
// Shared constants for the five-bit and three-bit GPIO port block
package gpfg_pkg;
  // Widths of the two ports
  localparam int WIDE_W = 5;
  localparam int NARROW_W = 3;
  // Number of pins shared with timer channels
  localparam int TMR_PINS = 4;
  // Lowest timer channel number on the wide port
  localparam int TMR_FIRST_CH = 2;
  // Register word indexes; the bus byte address is four times the index
  localparam logic [7:0] OFS_WIDE_DATA = 8'h09;
  localparam logic [7:0] OFS_NARROW_DATA = 8'h0A;
  localparam logic [7:0] OFS_WIDE_DIR = 8'h19;
  localparam logic [7:0] OFS_NARROW_DIR = 8'h1A;
  // Direction reset value: all pins input
  localparam logic [WIDE_W-1:0] WIDE_DIR_RST = 5'h00;
  localparam logic [NARROW_W-1:0] NARROW_DIR_RST = 3'h0;
  // Edge/level select code for plain GPIO use of a pin
  localparam logic [1:0] ELS_GPIO = 2'h0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Slave states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RESP = 2'b01
  } gpfg_wst_e;
endpackage : gpfg_pkg

// [rtl/gpfg_regif.sv]
// Register write strobes carried from bus slave to port logic
interface gpfg_regif_if;
  logic we_wide_data;
  logic we_narrow_data;
  logic we_wide_dir;
  logic we_narrow_dir;
  logic [7:0] wdata;
  modport slave (output we_wide_data, output we_narrow_data,
    output we_wide_dir, output we_narrow_dir, output wdata);
  modport port (input we_wide_data, input we_narrow_data,
    input we_wide_dir, input we_narrow_dir, input wdata);
endinterface : gpfg_regif_if

// [rtl/gpfg_port.sv]
// Latches and direction bits of both ports, timer pin muxing of the wide port
module gpfg_port (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register strobes
  gpfg_regif_if.port rif,
  // Timer side
  input wire logic [7:0] els,
  input wire logic [gpfg_pkg::TMR_PINS-1:0] tmr_out,
  input wire logic [gpfg_pkg::TMR_PINS-1:0] tmr_oe,
  // Pins
  input wire logic [gpfg_pkg::WIDE_W-1:0] wide_in,
  output logic [gpfg_pkg::WIDE_W-1:0] wide_out,
  output logic [gpfg_pkg::WIDE_W-1:0] wide_oe,
  input wire logic [gpfg_pkg::NARROW_W-1:0] narrow_in,
  output logic [gpfg_pkg::NARROW_W-1:0] narrow_out,
  output logic [gpfg_pkg::NARROW_W-1:0] narrow_oe,
  // Read views
  output logic [gpfg_pkg::WIDE_W-1:0] wide_rd,
  output logic [gpfg_pkg::NARROW_W-1:0] narrow_rd,
  output logic [gpfg_pkg::WIDE_W-1:0] wide_dir,
  output logic [gpfg_pkg::NARROW_W-1:0] narrow_dir
);
  // Data latches: no reset on purpose, contents survive reset
  logic [gpfg_pkg::WIDE_W-1:0] wide_latch_q;
  logic [gpfg_pkg::NARROW_W-1:0] narrow_latch_q;
  logic [gpfg_pkg::WIDE_W-1:0] wide_dir_q;
  logic [gpfg_pkg::NARROW_W-1:0] narrow_dir_q;
  logic [gpfg_pkg::WIDE_W-1:0] timer_owns;

  // Latch writes, accepted whatever the direction
  always_ff @(posedge clk) begin
    if (rif.we_wide_data) begin
      wide_latch_q <= rif.wdata[gpfg_pkg::WIDE_W-1:0];
    end
    if (rif.we_narrow_data) begin
      narrow_latch_q <= rif.wdata[gpfg_pkg::NARROW_W-1:0];
    end
  end

  // Direction registers clear to input on reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wide_dir_q <= gpfg_pkg::WIDE_DIR_RST;
      narrow_dir_q <= gpfg_pkg::NARROW_DIR_RST;
    end else begin
      if (rif.we_wide_dir) begin
        wide_dir_q <= rif.wdata[gpfg_pkg::WIDE_W-1:0];
      end
      if (rif.we_narrow_dir) begin
        narrow_dir_q <= rif.wdata[gpfg_pkg::NARROW_W-1:0];
      end
    end
  end

  // Pin ownership: a non-GPIO select hands the pin to the timer
  genvar g;
  generate
    for (g = 0; g < gpfg_pkg::WIDE_W; g++) begin : g_own
      if (g < gpfg_pkg::TMR_PINS) begin : g_tmr
        assign timer_owns[g] = els[2*g+1:2*g] != gpfg_pkg::ELS_GPIO;
        // Timer drives the pin while it owns it
        assign wide_out[g] = timer_owns[g] ? tmr_out[g] : wide_latch_q[g];
        assign wide_oe[g] = timer_owns[g] ? tmr_oe[g] : wide_dir_q[g];
      end else begin : g_plain
        assign timer_owns[g] = 1'b0;
        assign wide_out[g] = wide_latch_q[g];
        assign wide_oe[g] = wide_dir_q[g];
      end
    end
  endgenerate

  // Readback: latch where output, pin level where input
  assign wide_rd = (wide_dir_q & wide_latch_q) | (~wide_dir_q & wide_in);
  assign narrow_rd = (narrow_dir_q & narrow_latch_q)
    | (~narrow_dir_q & narrow_in);
  assign narrow_out = narrow_latch_q;
  assign narrow_oe = narrow_dir_q;
  assign wide_dir = wide_dir_q;
  assign narrow_dir = narrow_dir_q;
endmodule : gpfg_port

// [rtl/gpfg_top.sv]
// AXI4-Lite GPIO block with a five-bit and a three-bit port
// What this block does
// - Five wide-port latches, readable, kept over reset
// - Wide direction one drives pin, zero floats
// - Reset clears wide direction bits to input
// - Wide read: latch if output, pin if input
// - Latch writes accepted whatever the direction (lane 0 strobe needed), never affect input
// - Wide bits 0..3 serve timer channels 2..5
// - Edge/level select gives pin to timer
// - Timer-owned pin ignores direction for driver
// - Three narrow-port latches, readable, kept over reset
// - Narrow direction one drives pin, zero floats
// - Reset clears narrow direction bits to input
// - Narrow read: latch if output, pin if input
module gpfg_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // AXI4-Lite write address
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // AXI4-Lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read address
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Timer channels 2..5: two select bits each, drive and enable
  input wire logic [7:0] EDGE_LEVEL_SELECT,
  input wire logic [3:0] TIMER_CHANNEL_OUT,
  input wire logic [3:0] TIMER_CHANNEL_OE,
  output logic [3:0] TIMER_CHANNEL_PINS,
  // Wide port pins
  input wire logic [4:0] WIDE_PIN_IN,
  output logic [4:0] WIDE_PIN_OUT,
  output logic [4:0] WIDE_PIN_OE,
  // Narrow port pins
  input wire logic [2:0] NARROW_PIN_IN,
  output logic [2:0] NARROW_PIN_OUT,
  output logic [2:0] NARROW_PIN_OE
);
  // Write-side state: address and data latched separately
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic [1:0] bresp_q;
  logic bvalid_q;
  gpfg_pkg::gpfg_wst_e rst_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic rvalid_q;
  logic [7:0] rd_mux;
  // Word index of the read address, compared against register indexes
  logic [7:0] ar_idx;
  logic rd_hit;
  logic wr_fire;
  logic wr_hit;
  logic [4:0] wide_rd;
  logic [2:0] narrow_rd;
  logic [4:0] wide_dir;
  logic [2:0] narrow_dir;

  gpfg_regif_if rif ();

  // Handshakes: accept each channel once until the response leaves
  assign S_AXI_AWREADY = !aw_have_q && !bvalid_q;
  assign S_AXI_WREADY = !w_have_q && !bvalid_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;

  // Write commits the cycle after both address and data are held
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wr_hit = aw_addr_q == gpfg_pkg::OFS_WIDE_DATA
    || aw_addr_q == gpfg_pkg::OFS_NARROW_DATA
    || aw_addr_q == gpfg_pkg::OFS_WIDE_DIR
    || aw_addr_q == gpfg_pkg::OFS_NARROW_DIR;
  // Only byte lane 0 carries register bits; other lanes are ignored
  assign rif.wdata = w_data_q;
  assign rif.we_wide_data = wr_fire && w_lane_q
    && aw_addr_q == gpfg_pkg::OFS_WIDE_DATA;
  assign rif.we_narrow_data = wr_fire && w_lane_q
    && aw_addr_q == gpfg_pkg::OFS_NARROW_DATA;
  assign rif.we_wide_dir = wr_fire && w_lane_q
    && aw_addr_q == gpfg_pkg::OFS_WIDE_DIR;
  assign rif.we_narrow_dir = wr_fire && w_lane_q
    && aw_addr_q == gpfg_pkg::OFS_NARROW_DIR;

  // Write channel capture and response
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= gpfg_pkg::RESP_OKAY;
      rst_q <= gpfg_pkg::ST_IDLE;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_q <= 1'b1;
        // Keep the word index: byte lanes below it carry no register
        aw_addr_q <= {2'b00, S_AXI_AWADDR[7:2]};
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_q <= 1'b1;
        w_data_q <= S_AXI_WDATA[7:0];
        w_lane_q <= S_AXI_WSTRB[0];
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? gpfg_pkg::RESP_OKAY : gpfg_pkg::RESP_SLVERR;
        rst_q <= gpfg_pkg::ST_RESP;
      end else if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
        rst_q <= gpfg_pkg::ST_IDLE;
      end
    end
  end

  // Read decode: direction-dependent views from the port logic
  assign ar_idx = {2'b00, S_AXI_ARADDR[7:2]};
  assign rd_mux =
    (ar_idx == gpfg_pkg::OFS_WIDE_DATA) ?
      {3'h0, wide_rd} :
    (ar_idx == gpfg_pkg::OFS_NARROW_DATA) ?
      {5'h00, narrow_rd} :
    (ar_idx == gpfg_pkg::OFS_WIDE_DIR) ?
      {3'h0, wide_dir} :
    (ar_idx == gpfg_pkg::OFS_NARROW_DIR) ?
      {5'h00, narrow_dir} : 8'h00;
  assign rd_hit =
    ar_idx == gpfg_pkg::OFS_WIDE_DATA
    || ar_idx == gpfg_pkg::OFS_NARROW_DATA
    || ar_idx == gpfg_pkg::OFS_WIDE_DIR
    || ar_idx == gpfg_pkg::OFS_NARROW_DIR;

  // Read channel: data registered one cycle after the address
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= gpfg_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_mux};
      rresp_q <= rd_hit ? gpfg_pkg::RESP_OKAY : gpfg_pkg::RESP_SLVERR;
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // Port logic
  gpfg_port u_port (
    .clk (CLK),
    .rst (SYS_RST),
    .rif (rif.port),
    .els (EDGE_LEVEL_SELECT),
    .tmr_out (TIMER_CHANNEL_OUT),
    .tmr_oe (TIMER_CHANNEL_OE),
    .wide_in (WIDE_PIN_IN),
    .wide_out (WIDE_PIN_OUT),
    .wide_oe (WIDE_PIN_OE),
    .narrow_in (NARROW_PIN_IN),
    .narrow_out (NARROW_PIN_OUT),
    .narrow_oe (NARROW_PIN_OE),
    .wide_rd (wide_rd),
    .narrow_rd (narrow_rd),
    .wide_dir (wide_dir),
    .narrow_dir (narrow_dir)
  );

  // Timer capture sees the pin levels of its four shared pins
  assign TIMER_CHANNEL_PINS = WIDE_PIN_IN[3:0];
endmodule : gpfg_top

// [test/gpfg_pins_model.sv]
// Outside circuit on the port pins
module gpfg_pins_model (
  // Device drive and enable, narrow bits on top
  input wire logic [7:0] drv,
  input wire logic [7:0] en,
  // Level the outside applies to undriven pins
  input wire logic [7:0] ext,
  // Level seen on each pin
  output logic [7:0] lvl
);
  // Driven pins follow the device; no pull, so others show ext
  assign lvl = (en & drv) | (~en & ext);
endmodule // gpfg_pins_model

// [test/gpfg_checker.sv]
// Port-level assertions for the GPIO block
module gpfg_checker (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Bus answers
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Timer and pins
  input wire logic [7:0] EDGE_LEVEL_SELECT,
  input wire logic [3:0] TIMER_CHANNEL_OUT,
  input wire logic [3:0] TIMER_CHANNEL_OE,
  input wire logic [3:0] TIMER_CHANNEL_PINS,
  input wire logic [4:0] WIDE_PIN_IN,
  input wire logic [4:0] WIDE_PIN_OUT,
  input wire logic [4:0] WIDE_PIN_OE,
  input wire logic [2:0] NARROW_PIN_OE
);
  // Pins claimed by a timer channel, and those it drives
  wire logic [3:0] own;
  wire logic [3:0] tdrv;
  assign own = {|EDGE_LEVEL_SELECT[7:6], |EDGE_LEVEL_SELECT[5:4],
    |EDGE_LEVEL_SELECT[3:2], |EDGE_LEVEL_SELECT[1:0]};
  assign tdrv = own & TIMER_CHANNEL_OE;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  a_pin_mirror: assert property (TIMER_CHANNEL_PINS == WIDE_PIN_IN[3:0])
    else $error("timer pins differ");
  a_timer_oe: assert property ((WIDE_PIN_OE[3:0] & own) == tdrv)
    else $error("owned pin enable wrong");
  a_timer_out: assert property ((WIDE_PIN_OUT[3:0] & tdrv) ==
    (TIMER_CHANNEL_OUT & tdrv)) else $error("owned pin level wrong");
  a_reset_input: assert property ($fell(SYS_RST) |->
    NARROW_PIN_OE == 3'h0 && (WIDE_PIN_OE & ~{1'b0, own}) == 5'h00)
    else $error("pin driven after reset");
  a_wide_dir_write: assert property ($changed(WIDE_PIN_OE[4]) |->
    ##[0:2] S_AXI_BVALID) else $error("wide drive without write");
  a_narrow_dir_write: assert property ($changed(NARROW_PIN_OE) |->
    ##[0:2] S_AXI_BVALID) else $error("narrow drive without write");
  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer lost");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer lost");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
    S_AXI_RVALID) else $error("read not answered");
endmodule // gpfg_checker
bind gpfg_top gpfg_checker u_chk (.CLK, .SYS_RST, .S_AXI_BRESP, .S_AXI_BVALID,
  .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID,
  .S_AXI_RREADY, .EDGE_LEVEL_SELECT, .TIMER_CHANNEL_OUT, .TIMER_CHANNEL_OE,
  .TIMER_CHANNEL_PINS, .WIDE_PIN_IN, .WIDE_PIN_OUT, .WIDE_PIN_OE,
  .NARROW_PIN_OE);

// [test/tb_gpfg_top.sv]
// Self-checking bench for the GPIO block
module tb_gpfg_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Row: write, timer selects, outside pins, read, expected data, drivers
  typedef struct packed {
    logic [7:0] wa, wd, els, ext, ra, rx, oe;
  } gpfg_row_s;
  // Bus byte addresses: four times the register word indexes
  localparam logic [7:0] ADR_WD = gpfg_pkg::OFS_WIDE_DATA << 2;
  localparam logic [7:0] ADR_ND = gpfg_pkg::OFS_NARROW_DATA << 2;
  localparam logic [7:0] ADR_WR = gpfg_pkg::OFS_WIDE_DIR << 2;
  localparam logic [7:0] ADR_NR = gpfg_pkg::OFS_NARROW_DIR << 2;
  localparam gpfg_row_s ROWS [10] = '{
    '{ADR_WD, 8'h15, 8'h00, 8'h4A, ADR_WD, 8'h0A, 8'h00},
    '{ADR_ND, 8'h05, 8'h00, 8'h4A, ADR_ND, 8'h02, 8'h00},
    '{ADR_WR, 8'h1F, 8'h00, 8'h4A, ADR_WD, 8'h15, 8'h1F},
    '{ADR_WR, 8'h03, 8'h00, 8'h4A, ADR_WD, 8'h09, 8'h03},
    '{ADR_NR, 8'h05, 8'h00, 8'h4A, ADR_ND, 8'h07, 8'hA3},
    '{ADR_ND, 8'h00, 8'h00, 8'h4A, ADR_ND, 8'h02, 8'hA3},
    '{ADR_WR, 8'h03, 8'h05, 8'h4A, ADR_WD, 8'h09, 8'hA3},
    '{ADR_WR, 8'h00, 8'h0E, 8'h4A, ADR_WD, 8'h0A, 8'hA3},
    '{ADR_WR, 8'h1C, 8'h00, 8'h4A, ADR_WD, 8'h16, 8'hBC},
    '{ADR_ND, 8'h07, 8'h00, 8'h4A, ADR_NR, 8'h05, 8'hBC}};
  // Bus and pin stimulus
  logic clk, rst, aw_v, w_v, b_r, ar_v, r_r;
  logic [7:0] aw_a, ar_a, els, ext;
  logic [31:0] w_d, d;
  logic [3:0] t_out, t_oe, w_s;
  logic [1:0] r;
  // Design outputs, and the pin levels from the pins model
  wire logic aw_r, w_r, b_v, ar_r, r_v;
  wire logic [1:0] b_resp, r_resp;
  wire logic [31:0] r_d;
  wire logic [3:0] t_pins;
  wire logic [4:0] win, wout, woe;
  wire logic [2:0] nin, nout, noe;
  int compares, fail_count;
  gpfg_top DUT (.CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(aw_a),
    .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_r), .S_AXI_WDATA(w_d),
    .S_AXI_WSTRB(w_s), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_r),
    .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r),
    .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_r),
    .S_AXI_RDATA(r_d), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_v),
    .S_AXI_RREADY(r_r), .EDGE_LEVEL_SELECT(els), .TIMER_CHANNEL_OUT(t_out),
    .TIMER_CHANNEL_OE(t_oe), .TIMER_CHANNEL_PINS(t_pins),
    .WIDE_PIN_IN(win), .WIDE_PIN_OUT(wout), .WIDE_PIN_OE(woe),
    .NARROW_PIN_IN(nin), .NARROW_PIN_OUT(nout), .NARROW_PIN_OE(noe));
  gpfg_pins_model u_pins (.drv({nout, wout}), .en({noe, woe}), .ext(ext),
    .lvl({nin, win}));
  always #20 clk = ~clk;
  // Verdict and end of run
  task automatic results;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e, input string m);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  // Write: each channel released at the rising edge that takes it
  task automatic bus_wr(input logic [7:0] a, v);
    @(posedge clk);
    aw_a <= a;
    w_d <= {24'h00_0000, v};
    {aw_v, w_v, b_r} <= 3'b111;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      if (aw_v && aw_r) aw_v <= 1'b0;
      if (w_v && w_r) w_v <= 1'b0;
      if (b_v) begin
        r = b_resp;
        b_r <= 1'b0;
        return;
      end
    end
    fail_count++;
    results();
  endtask
  // Read with the same discipline
  task automatic bus_rd(input logic [7:0] a);
    @(posedge clk);
    ar_a <= a;
    {ar_v, r_r} <= 2'b11;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      if (ar_v && ar_r) ar_v <= 1'b0;
      if (r_v) begin
        d = r_d;
        r = r_resp;
        r_r <= 1'b0;
        return;
      end
    end
    fail_count++;
    results();
  endtask
  initial begin
    {clk, rst, aw_v, w_v, b_r, ar_v, r_r} = 7'h20;
    w_s = 4'hF;
    {aw_a, ar_a, els, ext, w_d} = 64'h0000_0000_0000_0000;
    {t_out, t_oe} = 8'hAF;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (ROWS[i]) begin
      els <= ROWS[i].els;
      ext <= ROWS[i].ext;
      bus_wr(ROWS[i].wa, ROWS[i].wd);
      chk(32'(r), 32'(gpfg_pkg::RESP_OKAY), "wresp");
      bus_rd(ROWS[i].ra);
      chk(d, 32'(ROWS[i].rx), "rdata");
      chk(32'({noe, woe}), 32'(ROWS[i].oe), "oe");
    end
    // Second reset: directions clear, latches survive
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk(32'({noe, woe}), 32'h0000_0000, "oe reset");
    bus_rd(ADR_WR);
    chk(d, 32'h0000_0000, "wdir reset");
    bus_rd(ADR_NR);
    chk(d, 32'h0000_0000, "ndir reset");
    bus_wr(ADR_NR, 8'h07);
    bus_rd(ADR_ND);
    chk(d, 32'h0000_0007, "nlatch kept");
    bus_wr(ADR_WR, 8'h1F);
    bus_rd(ADR_WD);
    chk(d, 32'h0000_0015, "wlatch kept");
    // Lane 0 strobe off: answered, but the latch keeps its value
    w_s <= 4'h0;
    bus_wr(ADR_ND, 8'h00);
    chk(32'(r), 32'(gpfg_pkg::RESP_OKAY), "lane off");
    w_s <= 4'hF;
    bus_rd(ADR_ND);
    chk(d, 32'h0000_0007, "lane off kept");
    bus_wr(8'h40, 8'h1F);
    chk(32'(r), 32'(gpfg_pkg::RESP_SLVERR), "unmapped w");
    bus_rd(8'h40);
    chk(32'(r), 32'(gpfg_pkg::RESP_SLVERR), "unmapped r");
    results();
  end
endmodule // tb_gpfg_top
